// *** core/cam_trig_pkg.sv ***
// Purpose: Shared constants and carrier types for the trigger/strobe register group
// Assumes: 32-bit registers, bit 0 of a field table is the vector MSB
// Notes: Field positions below are vector indices (table bit n is vector bit 31-n)
package cam_trig_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned NUM_PINS = 4;

  localparam logic [15:0] OFF_SHUT_LIM = 16'h1098;
  localparam logic [15:0] OFF_GAIN_LIM = 16'h10a0;
  localparam logic [15:0] OFF_IO_LEVELS = 16'h1100;
  localparam logic [15:0] OFF_OPTIONS = 16'h1104;
  localparam logic [15:0] OFF_TRIG_DELAY = 16'h1108;

  localparam int PRESENT_BIT = 31;
  localparam int SHUT_MIN_HI = 23;
  localparam int SHUT_MIN_LO = 16;
  localparam int SHUT_MAX_HI = 15;
  localparam int SHUT_MAX_LO = 0;
  localparam int GAIN_ON_BIT = 25;
  localparam int GAIN_MIN_HI = 23;
  localparam int GAIN_MIN_LO = 12;
  localparam int GAIN_MAX_HI = 11;
  localparam int GAIN_MAX_LO = 0;
  localparam int PIN_CNT_HI = 19;
  localparam int PIN_CNT_LO = 16;
  localparam int PIN_VAL_HI = 3;
  localparam int PIN_VAL_LO = 0;
  localparam int ORIGIN_BIT = 31;
  localparam int HOLD_BIT = 30;
  localparam int SCALE_HI = 7;
  localparam int SCALE_LO = 0;
  localparam int DELAY_HI = 15;
  localparam int DELAY_LO = 0;

  // Largest shutter value allowed as an automatic limit
  localparam logic [15:0] SHUT_LIMIT_CAP = 16'h0fa0;

  localparam logic [7:0] SHUT_MIN_RST = 8'h00;
  localparam logic [15:0] SHUT_MAX_RST = 16'h0fa0;
  localparam logic GAIN_ON_RST = 1'b0;
  localparam logic [11:0] GAIN_MIN_RST = 12'h000;
  localparam logic [11:0] GAIN_MAX_RST = 12'hfff;
  localparam logic ORIGIN_RST = 1'b0;
  localparam logic HOLD_RST = 1'b0;
  localparam logic [7:0] SCALE_RST = 8'h00;
  localparam logic [15:0] DELAY_RST = 16'h0000;
  localparam logic [3:0] PIN_COUNT = 4'h4;

  // Timing ticks run at 49.152 MHz against a 20 MHz system clock
  localparam longint unsigned CLK_HZ = 20_000_000;
  localparam longint unsigned TICK_HZ = 49_152_000;
  localparam int unsigned FRAC_W = 16;
  localparam logic [31:0] TICK_STEP = 32'((TICK_HZ << FRAC_W) / CLK_HZ);

  typedef struct packed {
    logic [15:0] hi;
    logic [7:0] lo;
  } shut_lim_s;

  typedef struct packed {
    logic on;
    logic [11:0] hi;
    logic [11:0] lo;
  } gain_lim_s;

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_DELAY = 3'b010,
    S_EXPOSE = 3'b100
  } seq_state_e;
endpackage : cam_trig_pkg

// *** core/scaled_delay.sv ***
// Purpose: Measures a programmed delay in timing ticks, stretched by a scale factor
// Assumes: i_start is a one-cycle pulse; length and scale are sampled at start
// Notes: Ticks are tracked in fixed point since a tick is shorter than one clock
`timescale 1ns/1ps
module scaled_delay (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_start,
  input wire logic [15:0] i_len,
  input wire logic [7:0] i_scale,
  output logic o_busy,
  output logic o_done
);
  logic [23:0] target_q;
  logic [39:0] acc_q;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      target_q <= 24'h00_0000;
      acc_q <= 40'h00_0000_0000;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        // Effective length is field times (scale plus one)
        target_q <= 24'({8'h00, i_len} * ({16'h0000, i_scale} + 24'h00_0001));
        acc_q <= 40'h00_0000_0000;
        o_busy <= 1'b1;
      end else if (o_busy) begin
        if (acc_q[39:16] >= target_q) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end else begin
          acc_q <= acc_q + {8'h00, cam_trig_pkg::TICK_STEP};
        end
      end
    end
  end
endmodule : scaled_delay

// *** core/camera_trigger_strobe_regs.sv ***
// Purpose: Trigger/strobe timing registers and the auto exposure limit registers
// Assumes: Plain register port, read data valid the cycle after the read strobe
// Notes: Pins and trigger are asynchronous and pass a three-stage synchroniser
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module camera_trigger_strobe_regs #(
  parameter bit ASYNC_FORCES_TRIG_ORIGIN = 1'b1,
  parameter bit SHUT_LIM_PRESENT = 1'b1,
  parameter bit GAIN_LIM_PRESENT = 1'b1,
  parameter bit IO_PRESENT = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [cam_trig_pkg::ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [31:0] o_rd_data,
  input wire logic [cam_trig_pkg::NUM_PINS-1:0] i_pins,
  input wire logic i_ext_trigger,
  input wire logic i_async_trig_mode,
  input wire logic i_exposure_done,
  input wire logic [15:0] i_mode_shut_min,
  input wire logic [15:0] i_mode_shut_max,
  input wire logic [15:0] i_strobe_delay,
  input wire logic [15:0] i_strobe_width,
  output cam_trig_pkg::shut_lim_s o_shut_lim,
  output cam_trig_pkg::gain_lim_s o_gain_lim,
  output logic o_awb_boost_en,
  output logic o_integrate,
  output logic o_strobe,
  output logic o_trig_dropped
);
  localparam int NS = cam_trig_pkg::NUM_PINS + 1;

  // Stored register fields
  logic [7:0] shut_min_q;
  logic [15:0] shut_max_q;
  logic gain_on_q;
  logic [11:0] gain_min_q;
  logic [11:0] gain_max_q;
  logic origin_q;
  logic hold_q;
  logic [7:0] scale_q;
  logic [15:0] delay_q;

  // Synchroniser and trigger detection
  logic [NS-1:0] sync1_q;
  logic [NS-1:0] sync2_q;
  logic [NS-1:0] sync3_q;
  logic [NS-1:0] stable_q;
  logic trig_prev_q;
  logic trig_evt;

  // Sequencer
  cam_trig_pkg::seq_state_e state_q;
  logic pending_q;
  logic shut_start;
  logic shut_done;
  logic integ_start;
  logic strobe_from_trig;
  logic strb_dly_start;
  logic strb_dly_done;
  logic strb_wid_done;
  logic strb_wid_busy;

  logic wr_shut;
  logic wr_gain;
  logic wr_opt;
  logic wr_dly;
  logic [31:0] rd_mux;
  logic [15:0] wr_max_clamp;
  logic [7:0] wr_min_clamp;

  assign wr_shut = i_wr_en && (i_addr == cam_trig_pkg::OFF_SHUT_LIM);
  assign wr_gain = i_wr_en && (i_addr == cam_trig_pkg::OFF_GAIN_LIM);
  assign wr_opt = i_wr_en && (i_addr == cam_trig_pkg::OFF_OPTIONS);
  assign wr_dly = i_wr_en && (i_addr == cam_trig_pkg::OFF_TRIG_DELAY);

  // Bounds above the cap are pulled down to it on write
  always_comb begin
    wr_max_clamp = i_wr_data[cam_trig_pkg::SHUT_MAX_HI:cam_trig_pkg::SHUT_MAX_LO];
    if (wr_max_clamp > cam_trig_pkg::SHUT_LIMIT_CAP) begin
      wr_max_clamp = cam_trig_pkg::SHUT_LIMIT_CAP;
    end
    wr_min_clamp = i_wr_data[cam_trig_pkg::SHUT_MIN_HI:cam_trig_pkg::SHUT_MIN_LO];
  end

  // Shutter limit register; reserved bits are not stored
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      shut_min_q <= cam_trig_pkg::SHUT_MIN_RST;
      shut_max_q <= cam_trig_pkg::SHUT_MAX_RST;
    end else if (wr_shut) begin
      shut_min_q <= wr_min_clamp;
      shut_max_q <= wr_max_clamp;
    end
  end

  // Gain limit register
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      gain_on_q <= cam_trig_pkg::GAIN_ON_RST;
      gain_min_q <= cam_trig_pkg::GAIN_MIN_RST;
      gain_max_q <= cam_trig_pkg::GAIN_MAX_RST;
    end else if (wr_gain) begin
      gain_on_q <= i_wr_data[cam_trig_pkg::GAIN_ON_BIT];
      // Lock follows the state before this write, so one write cannot
      // both enable the function and change its bounds
      if (gain_on_q) begin
        gain_min_q <= i_wr_data[cam_trig_pkg::GAIN_MIN_HI:cam_trig_pkg::GAIN_MIN_LO];
        gain_max_q <= i_wr_data[cam_trig_pkg::GAIN_MAX_HI:cam_trig_pkg::GAIN_MAX_LO];
      end
    end
  end

  // Strobe/trigger options register
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      origin_q <= cam_trig_pkg::ORIGIN_RST;
      hold_q <= cam_trig_pkg::HOLD_RST;
      scale_q <= cam_trig_pkg::SCALE_RST;
    end else if (wr_opt) begin
      origin_q <= i_wr_data[cam_trig_pkg::ORIGIN_BIT];
      hold_q <= i_wr_data[cam_trig_pkg::HOLD_BIT];
      scale_q <= i_wr_data[cam_trig_pkg::SCALE_HI:cam_trig_pkg::SCALE_LO];
    end
  end

  // Trigger-to-integration delay register
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      delay_q <= cam_trig_pkg::DELAY_RST;
    end else if (wr_dly) begin
      delay_q <= i_wr_data[cam_trig_pkg::DELAY_HI:cam_trig_pkg::DELAY_LO];
    end
  end

  // Three-stage synchroniser; a level counts once stages two and three agree
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      stable_q <= '0;
    end else begin
      sync1_q <= {i_ext_trigger, i_pins};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      for (int i = 0; i < NS; i++) begin
        if (sync2_q[i] == sync3_q[i]) begin
          stable_q[i] <= sync3_q[i];
        end
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= stable_q[NS-1];
    end
  end

  assign trig_evt = stable_q[NS-1] && !trig_prev_q;

  // Read mux: reserved bits stay zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (i_addr)
      cam_trig_pkg::OFF_SHUT_LIM: begin
        rd_mux[cam_trig_pkg::PRESENT_BIT] = SHUT_LIM_PRESENT;
        rd_mux[cam_trig_pkg::SHUT_MIN_HI:cam_trig_pkg::SHUT_MIN_LO] = shut_min_q;
        rd_mux[cam_trig_pkg::SHUT_MAX_HI:cam_trig_pkg::SHUT_MAX_LO] = shut_max_q;
      end
      cam_trig_pkg::OFF_GAIN_LIM: begin
        rd_mux[cam_trig_pkg::PRESENT_BIT] = GAIN_LIM_PRESENT;
        rd_mux[cam_trig_pkg::GAIN_ON_BIT] = gain_on_q;
        rd_mux[cam_trig_pkg::GAIN_MIN_HI:cam_trig_pkg::GAIN_MIN_LO] = gain_min_q;
        rd_mux[cam_trig_pkg::GAIN_MAX_HI:cam_trig_pkg::GAIN_MAX_LO] = gain_max_q;
      end
      cam_trig_pkg::OFF_IO_LEVELS: begin
        rd_mux[cam_trig_pkg::PRESENT_BIT] = IO_PRESENT;
        rd_mux[cam_trig_pkg::PIN_CNT_HI:cam_trig_pkg::PIN_CNT_LO] =
          cam_trig_pkg::PIN_COUNT;
        // Pin 0 lands in the last bit, pin 3 in bit 28
        rd_mux[cam_trig_pkg::PIN_VAL_HI:cam_trig_pkg::PIN_VAL_LO] =
          stable_q[cam_trig_pkg::NUM_PINS-1:0];
      end
      cam_trig_pkg::OFF_OPTIONS: begin
        rd_mux[cam_trig_pkg::ORIGIN_BIT] = origin_q;
        rd_mux[cam_trig_pkg::HOLD_BIT] = hold_q;
        rd_mux[cam_trig_pkg::SCALE_HI:cam_trig_pkg::SCALE_LO] = scale_q;
      end
      cam_trig_pkg::OFF_TRIG_DELAY: begin
        rd_mux[cam_trig_pkg::DELAY_HI:cam_trig_pkg::DELAY_LO] = delay_q;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rd_data <= 32'h0000_0000;
    end else if (i_rd_en) begin
      o_rd_data <= rd_mux;
    end else begin
      o_rd_data <= 32'h0000_0000;
    end
  end

  // Limits handed to the exposure controller, narrowed to the grab range
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_shut_lim <= '0;
    end else begin
      if ({8'h00, shut_min_q} < i_mode_shut_min) begin
        o_shut_lim.lo <= (|i_mode_shut_min[15:8]) ? 8'hff : i_mode_shut_min[7:0];
      end else begin
        o_shut_lim.lo <= shut_min_q;
      end
      if (shut_max_q > i_mode_shut_max) begin
        o_shut_lim.hi <= i_mode_shut_max;
      end else begin
        o_shut_lim.hi <= shut_max_q;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_gain_lim <= '0;
      o_awb_boost_en <= 1'b0;
    end else begin
      o_gain_lim.on <= gain_on_q;
      o_gain_lim.lo <= gain_min_q;
      o_gain_lim.hi <= gain_max_q;
      o_awb_boost_en <= gain_on_q;
    end
  end

  // Frame sequencer: trigger, delay, then integration
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= cam_trig_pkg::S_IDLE;
    end else begin
      unique case (state_q)
        cam_trig_pkg::S_IDLE: begin
          if (trig_evt || pending_q) begin
            state_q <= cam_trig_pkg::S_DELAY;
          end
        end
        cam_trig_pkg::S_DELAY: begin
          if (shut_done) begin
            state_q <= cam_trig_pkg::S_EXPOSE;
          end
        end
        cam_trig_pkg::S_EXPOSE: begin
          if (i_exposure_done) begin
            state_q <= cam_trig_pkg::S_IDLE;
          end
        end
        default: begin
          state_q <= cam_trig_pkg::S_IDLE;
        end
      endcase
    end
  end

  assign shut_start = (state_q == cam_trig_pkg::S_IDLE) && (trig_evt || pending_q);
  assign integ_start = (state_q == cam_trig_pkg::S_DELAY) && shut_done;

  // Queued trigger; only a trigger during integration is queued, and the next start clears it
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pending_q <= 1'b0;
      o_trig_dropped <= 1'b0;
    end else begin
      o_trig_dropped <= 1'b0;
      if (trig_evt && (state_q == cam_trig_pkg::S_EXPOSE)) begin
        if (hold_q) begin
          o_trig_dropped <= 1'b1;
        end else begin
          pending_q <= 1'b1;
        end
      end else if (shut_start) begin
        pending_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_integrate <= 1'b0;
    end else if (integ_start) begin
      o_integrate <= 1'b1;
    end else if ((state_q == cam_trig_pkg::S_EXPOSE) && i_exposure_done) begin
      o_integrate <= 1'b0;
    end
  end

  // Trigger-to-integration delay, scaled
  scaled_delay u_shut_delay (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_start(shut_start),
    .i_len(delay_q),
    .i_scale(scale_q),
    .o_busy(),
    .o_done(shut_done)
  );

  // Async trigger mode may force trigger-relative strobe timing
  assign strobe_from_trig = origin_q || (ASYNC_FORCES_TRIG_ORIGIN && i_async_trig_mode);
  assign strb_dly_start = strobe_from_trig ? shut_start : integ_start;

  // Strobe delay and strobe width share the same scale
  scaled_delay u_strobe_delay (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_start(strb_dly_start),
    .i_len(i_strobe_delay),
    .i_scale(scale_q),
    .o_busy(),
    .o_done(strb_dly_done)
  );

  scaled_delay u_strobe_width (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_start(strb_dly_done),
    .i_len(i_strobe_width),
    .i_scale(scale_q),
    .o_busy(strb_wid_busy),
    .o_done(strb_wid_done)
  );

  // Registered so the pin never sees a combinational glitch
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_strobe <= 1'b0;
    end else begin
      o_strobe <= strb_wid_busy && !strb_wid_done;
    end
  end
endmodule : camera_trigger_strobe_regs

// *** verif/camera_trigger_strobe_regs_assertions.sv ***
// Purpose: Port-level checks for the trigger/strobe register group
// Assumes: One clock domain, read data in the cycle after the read strobe
// Notes: Bound from the bench top file
`timescale 1ns/1ps
module cam_regs_checker (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [cam_trig_pkg::ADDR_W-1:0] i_addr,
  input wire logic i_rd_en,
  input wire logic [31:0] o_rd_data,
  input wire cam_trig_pkg::shut_lim_s o_shut_lim,
  input wire cam_trig_pkg::gain_lim_s o_gain_lim,
  input wire logic o_awb_boost_en,
  input wire logic o_trig_dropped
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic mapped;
  assign mapped = i_addr inside {16'h1098, 16'h10a0, 16'h1100, 16'h1104, 16'h1108};
  sequence s_rd(logic [15:0] a);
    i_rd_en && i_addr == a;
  endsequence
  a_unmapped_reads_zero: assert property (i_rd_en && !mapped |=> o_rd_data == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_io_status_fixed: assert property (s_rd(16'h1100) |=> o_rd_data[31:4] == 28'h800_4000)
    else $error("io status fixed fields wrong");
  a_shut_read_form: assert property (s_rd(16'h1098) |=> o_rd_data[31:24] == 8'h80
    && o_rd_data[15:0] <= cam_trig_pkg::SHUT_LIMIT_CAP) else $error("shutter limit read wrong");
  a_gain_read_form: assert property (s_rd(16'h10a0) |=> o_rd_data[31:26] == 6'h20 && !o_rd_data[24])
    else $error("gain limit reserved bits set");
  a_opts_reserved_zero: assert property (s_rd(16'h1104) |=> o_rd_data[29:8] == 22'h00_0000)
    else $error("options reserved bits set");
  a_delay_reserved_zero: assert property (s_rd(16'h1108) |=> o_rd_data[31:16] == 16'h0000)
    else $error("delay reserved bits set");
  a_shut_out_cap: assert property (o_shut_lim.hi <= cam_trig_pkg::SHUT_LIMIT_CAP)
    else $error("shutter limit above cap");
  a_boost_follows_on: assert property (o_awb_boost_en == o_gain_lim.on)
    else $error("boost differs from gain on bit");
  a_drop_single_pulse: assert property (o_trig_dropped |=> !o_trig_dropped)
    else $error("drop pulse too long");
endmodule : cam_regs_checker

// *** verif/exposure_end_model.sv ***
// Purpose: Sensor side that closes each integration after a set length
// Assumes: Integration is a level from the block
// Notes: Done is a one-cycle pulse, as the block expects
`timescale 1ns/1ps
module exposure_end_model (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_integrate,
  input wire logic [7:0] i_exp_len,
  output logic o_exposure_done
);
  logic [7:0] cnt_q;
  // Counts only while integrating, so a queued frame gets a full exposure
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_q <= 8'h00;
      o_exposure_done <= 1'b0;
    end else begin
      o_exposure_done <= 1'b0;
      if (!i_integrate || o_exposure_done) begin
        cnt_q <= 8'h00;
      end else if (cnt_q == i_exp_len) begin
        o_exposure_done <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
endmodule : exposure_end_model

// *** verif/camera_trigger_strobe_regs_tb_top.sv ***
// Purpose: Self-checking bench for the trigger/strobe register group
// Assumes: Host strobes last one cycle, read data one cycle later
// Notes: Frame times are windows since ticks and clocks are unrelated
`timescale 1ns/1ps
module camera_trigger_strobe_regs_tb_top;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [15:0] i_addr = 16'h0000;
  logic [31:0] i_wr_data = 32'h0000_0000;
  logic i_wr_en = 1'b0;
  logic i_rd_en = 1'b0;
  logic [31:0] o_rd_data;
  logic [3:0] i_pins = 4'h0;
  logic i_ext_trigger = 1'b0;
  logic i_async_trig_mode = 1'b0;
  logic i_exposure_done;
  logic [15:0] i_mode_shut_min = 16'h0000;
  logic [15:0] i_mode_shut_max = 16'hffff;
  logic [15:0] i_strobe_delay = 16'h0000;
  logic [7:0] exp_len = 8'h1e;
  cam_trig_pkg::shut_lim_s o_shut_lim;
  cam_trig_pkg::gain_lim_s o_gain_lim;
  logic o_awb_boost_en, o_integrate, o_strobe, o_trig_dropped;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int t_int, t_str, drops, rises, ta, tb;
  always #25 i_clk = ~i_clk;
  camera_trigger_strobe_regs uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
    .i_pins(i_pins), .i_ext_trigger(i_ext_trigger), .i_async_trig_mode(i_async_trig_mode),
    .i_exposure_done(i_exposure_done), .i_mode_shut_min(i_mode_shut_min),
    .i_mode_shut_max(i_mode_shut_max), .i_strobe_delay(i_strobe_delay),
    .i_strobe_width(16'h0014),
    .o_shut_lim(o_shut_lim), .o_gain_lim(o_gain_lim), .o_awb_boost_en(o_awb_boost_en),
    .o_integrate(o_integrate), .o_strobe(o_strobe), .o_trig_dropped(o_trig_dropped));
  exposure_end_model u_exp (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_integrate(o_integrate),
    .i_exp_len(exp_len), .o_exposure_done(i_exposure_done));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wr_data <= d;
    i_wr_en <= 1'b1;
    @(posedge i_clk);
    i_wr_en <= 1'b0;
    @(posedge i_clk);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [31:0] exp, input string what);
    i_addr <= a;
    i_rd_en <= 1'b1;
    @(posedge i_clk);
    i_rd_en <= 1'b0;
    #1;
    chk(o_rd_data, exp, what);
    @(posedge i_clk);
  endtask : rd
  // One trigger, optionally a second one during integration; logs edges per cycle
  task frame(input bit second);
    bit prev;
    t_int = -1;
    t_str = -1;
    drops = 0;
    rises = 0;
    prev = 1'b0;
    i_ext_trigger <= 1'b1;
    for (int c = 0; c < 160; c++) begin
      @(posedge i_clk);
      if (c == 6) i_ext_trigger <= 1'b0;
      if (second && t_int >= 0 && c == t_int + 5) i_ext_trigger <= 1'b1;
      if (second && t_int >= 0 && c == t_int + 11) i_ext_trigger <= 1'b0;
      #1;
      if (o_integrate === 1'b1 && !prev) begin
        rises++;
        if (t_int < 0) t_int = c;
      end
      prev = (o_integrate === 1'b1);
      if (o_strobe === 1'b1 && t_str < 0) t_str = c;
      if (o_trig_dropped === 1'b1) drops++;
    end
    @(posedge i_clk);
  endtask : frame
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      $display("mismatch at %0t: timeout", $time);
      end_of_test();
    end
  end
  initial begin
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    rd(16'h1098, 32'h8000_0fa0, "shut reset");
    rd(16'h10a0, 32'h8000_0fff, "gain reset");
    rd(16'h1104, 32'h0000_0000, "opts reset");
    rd(16'h1108, 32'h0000_0000, "delay reset");
    rd(16'h109c, 32'h0000_0000, "unmapped");
    $display("test reset values done");
    wr(16'h1098, 32'hffff_ffff);
    rd(16'h1098, 32'h80ff_0fa0, "shut cap");
    wr(16'h1098, 32'h0010_0800);
    rd(16'h1098, 32'h8010_0800, "shut fields");
    chk({8'h00, o_shut_lim}, 32'h0008_0010, "shut out");
    i_mode_shut_min <= 16'h0020;
    i_mode_shut_max <= 16'h0400;
    repeat (4) @(negedge i_clk);
    chk({8'h00, o_shut_lim}, 32'h0004_0020, "mode clamp");
    @(posedge i_clk);
    i_mode_shut_min <= 16'h0000;
    i_mode_shut_max <= 16'hffff;
    $display("test shutter limits done");
    wr(16'h10a0, 32'h0012_3456);
    rd(16'h10a0, 32'h8000_0fff, "gain locked");
    wr(16'h10a0, 32'hffff_ffff);
    rd(16'h10a0, 32'h8200_0fff, "gain on");
    chk({31'h0, o_awb_boost_en}, 32'h0000_0001, "boost on");
    wr(16'h10a0, 32'h0212_3456);
    rd(16'h10a0, 32'h8212_3456, "gain fields");
    chk({7'h00, o_gain_lim}, 32'h0145_6123, "gain out");
    wr(16'h10a0, 32'h0000_0000);
    rd(16'h10a0, 32'h8000_0000, "gain off");
    chk({31'h0, o_awb_boost_en}, 32'h0000_0000, "boost off");
    $display("test gain limits done");
    i_pins <= 4'b1010;
    repeat (8) @(posedge i_clk);
    rd(16'h1100, 32'h8004_000a, "pins a");
    wr(16'h1100, 32'h0000_0000);
    i_pins <= 4'b0101;
    repeat (8) @(posedge i_clk);
    rd(16'h1100, 32'h8004_0005, "pins 5");
    wr(16'h1104, 32'hffff_ffff);
    rd(16'h1104, 32'hc000_00ff, "opts");
    wr(16'h1108, 32'hffff_ffff);
    rd(16'h1108, 32'h0000_ffff, "delay");
    $display("test io and options done");
    wr(16'h1104, 32'h0000_0000);
    wr(16'h1108, 32'h0000_0028);
    frame(1'b0);
    ta = t_int;
    chk({31'h0, t_str >= ta - 1}, 32'h0000_0001, "strobe from integ");
    wr(16'h1104, 32'h0000_0001);
    wr(16'h1108, 32'h0000_0014);
    frame(1'b0);
    tb = t_int;
    chk({31'h0, tb >= ta - 1 && tb <= ta + 1}, 32'h0000_0001, "scale 1");
    wr(16'h1104, 32'h0000_0003);
    i_strobe_delay <= 16'h000a;
    frame(1'b0);
    chk({31'h0, t_int - ta >= 15 && t_int - ta <= 18}, 32'h0000_0001, "scale 3");
    tb = t_str - t_int;
    chk({31'h0, tb >= 19 && tb <= 22}, 32'h0000_0001, "strobe scaled");
    i_strobe_delay <= 16'h0000;
    wr(16'h1104, 32'h8000_0000);
    wr(16'h1108, 32'h0000_0028);
    frame(1'b0);
    chk({31'h0, t_str >= 0 && t_str <= t_int - 10}, 32'h0000_0001, "strobe from trig");
    wr(16'h1104, 32'h0000_0000);
    i_async_trig_mode <= 1'b1;
    frame(1'b0);
    chk({31'h0, t_str >= 0 && t_str <= t_int - 10}, 32'h0000_0001, "async origin");
    i_async_trig_mode <= 1'b0;
    $display("test delays and strobe done");
    wr(16'h1108, 32'h0000_0000);
    wr(16'h1104, 32'h4000_0000);
    frame(1'b1);
    chk({31'h0, drops == 1 && rises == 1}, 32'h0000_0001, "trigger dropped");
    wr(16'h1104, 32'h0000_0000);
    frame(1'b1);
    chk({31'h0, drops == 0 && rises == 2}, 32'h0000_0001, "trigger queued");
    $display("test trigger hold done");
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    rd(16'h10a0, 32'h8000_0fff, "gain after reset");
    $display("test second reset done");
    end_of_test();
  end
endmodule : camera_trigger_strobe_regs_tb_top

bind camera_trigger_strobe_regs cam_regs_checker u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_addr(i_addr), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .o_shut_lim(o_shut_lim),
  .o_gain_lim(o_gain_lim), .o_awb_boost_en(o_awb_boost_en), .o_trig_dropped(o_trig_dropped));
